// *** rfa_pkg.sv ***
/*
   Shared definitions for the register field access bank: register offsets,
   reset values, field masks and the request and answer carriers.
   Assumes a single 32-bit data path and word-aligned accesses.
*/
package rfa_pkg;

   // -----------------------------------------------------------------
   // Register offsets from the bank's base address
   // -----------------------------------------------------------------
   localparam logic [11:0] OFS_CTRL     = 12'h000;
   localparam logic [11:0] OFS_STATUS   = 12'h004;
   localparam logic [11:0] OFS_CAPTURE  = 12'h008;
   localparam logic [11:0] OFS_ACCUM    = 12'h00C;
   localparam logic [11:0] OFS_RAW_INT  = 12'h010;
   localparam logic [11:0] OFS_SETBITS  = 12'h014;
   localparam logic [11:0] OFS_INT_CLR  = 12'h018;
   localparam logic [11:0] OFS_WDATA    = 12'h01C;

   // -----------------------------------------------------------------
   // Decode geometry and reset values
   // -----------------------------------------------------------------
   localparam int          OFS_BITS     = 12;
   localparam logic [31:0] BASE_DEFAULT = 32'h4000_0000;
   localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
   localparam logic [31:0] CTRL_MASK    = 32'h0000_FFFF;
   localparam logic [31:0] STATUS_MASK  = 32'h0000_00FF;
   localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;

   // -----------------------------------------------------------------
   // Carriers
   // -----------------------------------------------------------------
   typedef struct packed {
      logic        sel;
      logic        write;
      logic [31:0] addr;
      logic [31:0] wdata;
   } rfa_req_t;

   typedef struct packed {
      logic        valid;
      logic [31:0] rdata;
   } rfa_rsp_t;

endpackage

// *** rfa_bank.sv ***
/*
   Register bank demonstrating each field access type: read/write, read-only,
   clear-on-read, clear-on-any-write, write-one-to-clear, write-one-to-set,
   write-only clear and write-only data.
   Assumes requests are synchronous to core_clk_i and word aligned; answers
   come one cycle after the request is taken.
*/
`timescale 1ns/1ns

// Operation
// - Clear-on-read returns value, then clears
// - Read/write field stores and returns value
// - Any write clears the whole accumulate register
// - Write-one-to-clear: ones clear, zeros ignored
// - Writing back read value clears reported bits
// - Write-one-to-set: ones set, zeros ignored
// - Write-only clear: ones clear, reads meaningless
// - Clear register clears matching interrupt status
// - Write-only data accepts writes, read meaningless
// - Every field takes its reset value
// - Reserved bits read as zero
// - Decode offsets relative to base address
module rfa_bank #(
   parameter logic [31:0] BASE_ADDR = rfa_pkg::BASE_DEFAULT,
   parameter logic [31:0] CTRL_BITS = rfa_pkg::CTRL_MASK
) (
   // Clock and reset
   input  wire logic              core_clk_i,
   input  wire logic              reset_n_i,
   // Software access
   input  wire rfa_pkg::rfa_req_t req_i,
   output rfa_pkg::rfa_rsp_t      rsp_o,
   // Hardware events and status
   input  wire logic [31:0]       status_i,
   input  wire logic [31:0]       capture_event_i,
   input  wire logic [31:0]       accum_event_i,
   input  wire logic [31:0]       int_event_i,
   input  wire logic [31:0]       setbits_clear_i,
   // Field values toward the hardware
   output logic [31:0]            ctrl_o,
   output logic [31:0]            raw_int_o,
   output logic [31:0]            setbits_o,
   output logic [31:0]            wdata_o,
   output logic                   wdata_strobe_o
);

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   logic        in_window;
   logic [31:0] ctrl;
   logic [31:0] capture;
   logic [31:0] accum;
   logic [31:0] raw_int;
   logic [31:0] setbits;
   logic [31:0] wdata_reg;
   logic        wdata_strobe;
   logic [31:0] next_rdata;
   logic        hit_known;
   rfa_pkg::rfa_rsp_t rsp;

   // Base match on the upper bits, word alignment on the lowest two.
   assign in_window = req_i.sel
                      && (req_i.addr[31:rfa_pkg::OFS_BITS] == BASE_ADDR[31:rfa_pkg::OFS_BITS])
                      && (req_i.addr[1:0] == 2'h0);

   function automatic logic wr_at(input logic [11:0] ofs);
      wr_at = in_window && req_i.write && (req_i.addr[11:0] == ofs);
   endfunction

   function automatic logic rd_at(input logic [11:0] ofs);
      rd_at = in_window && !req_i.write && (req_i.addr[11:0] == ofs);
   endfunction

   // ----------------------------------------------------------------
   // Read/write control
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         ctrl <= rfa_pkg::CTRL_RESET;
      end
      else if (wr_at(rfa_pkg::OFS_CTRL))
      begin
         ctrl <= req_i.wdata & CTRL_BITS;
      end
   end

   // ----------------------------------------------------------------
   // Clear-on-read capture
   // ----------------------------------------------------------------
   // A new event in the read cycle survives the clear.
   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         capture <= rfa_pkg::ZERO_WORD;
      end
      else if (rd_at(rfa_pkg::OFS_CAPTURE))
      begin
         capture <= capture_event_i;
      end
      else
      begin
         capture <= capture | capture_event_i;
      end
   end

   // ----------------------------------------------------------------
   // Clear-on-any-write accumulator
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         accum <= rfa_pkg::ZERO_WORD;
      end
      else if (wr_at(rfa_pkg::OFS_ACCUM))
      begin
         accum <= accum_event_i;
      end
      else
      begin
         accum <= accum | accum_event_i;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt status, cleared by write-one through either register
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         raw_int <= rfa_pkg::ZERO_WORD;
      end
      else if (wr_at(rfa_pkg::OFS_RAW_INT) || wr_at(rfa_pkg::OFS_INT_CLR))
      begin
         raw_int <= (raw_int & ~req_i.wdata) | int_event_i;
      end
      else
      begin
         raw_int <= raw_int | int_event_i;
      end
   end

   // ----------------------------------------------------------------
   // Write-one-to-set bits, released by hardware
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         setbits <= rfa_pkg::ZERO_WORD;
      end
      else if (wr_at(rfa_pkg::OFS_SETBITS))
      begin
         setbits <= (setbits & ~setbits_clear_i) | req_i.wdata;
      end
      else
      begin
         setbits <= setbits & ~setbits_clear_i;
      end
   end

   // ----------------------------------------------------------------
   // Write-only data with a one-cycle strobe
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         wdata_reg    <= rfa_pkg::ZERO_WORD;
         wdata_strobe <= 1'b0;
      end
      else
      begin
         wdata_strobe <= wr_at(rfa_pkg::OFS_WDATA);
         if (wr_at(rfa_pkg::OFS_WDATA))
         begin
            wdata_reg <= req_i.wdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   always_comb
   begin
      next_rdata = rfa_pkg::ZERO_WORD;
      hit_known  = 1'b1;
      unique case (req_i.addr[11:0])
         rfa_pkg::OFS_CTRL:    next_rdata = ctrl;
         rfa_pkg::OFS_STATUS:  next_rdata = status_i & rfa_pkg::STATUS_MASK;
         rfa_pkg::OFS_CAPTURE: next_rdata = capture;
         rfa_pkg::OFS_ACCUM:   next_rdata = accum;
         rfa_pkg::OFS_RAW_INT: next_rdata = raw_int;
         rfa_pkg::OFS_SETBITS: next_rdata = setbits;
         rfa_pkg::OFS_INT_CLR: next_rdata = rfa_pkg::ZERO_WORD;
         rfa_pkg::OFS_WDATA:   next_rdata = rfa_pkg::ZERO_WORD;
         default:              hit_known  = 1'b0;
      endcase
      if (!(in_window && !req_i.write && hit_known))
      begin
         next_rdata = rfa_pkg::ZERO_WORD;
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         rsp.valid <= 1'b0;
         rsp.rdata <= rfa_pkg::ZERO_WORD;
      end
      else
      begin
         rsp.valid <= req_i.sel;
         rsp.rdata <= next_rdata;
      end
   end

   assign rsp_o          = rsp;
   assign ctrl_o         = ctrl;
   assign raw_int_o      = raw_int;
   assign setbits_o      = setbits;
   assign wdata_o        = wdata_reg;
   assign wdata_strobe_o = wdata_strobe;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_capture_read_value: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      rd_at(rfa_pkg::OFS_CAPTURE) |=> rsp.valid && rsp.rdata == $past(capture))
      else $error("capture read did not return the held value");

   chk_capture_read_clear: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      rd_at(rfa_pkg::OFS_CAPTURE) && capture_event_i == 32'h0 ##1 capture_event_i == 32'h0
      |=> capture == 32'h0)
      else $error("capture field not cleared after read");

   chk_ctrl_store: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      wr_at(rfa_pkg::OFS_CTRL) ##1 !wr_at(rfa_pkg::OFS_CTRL) ##1 rd_at(rfa_pkg::OFS_CTRL)
      |=> rsp.rdata == ($past(req_i.wdata, 3) & CTRL_BITS))
      else $error("control read back differs from write");

   chk_accum_any_write: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      wr_at(rfa_pkg::OFS_ACCUM) |=> accum == $past(accum_event_i))
      else $error("accumulator not cleared by write");

   chk_raw_w1c_keep: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      wr_at(rfa_pkg::OFS_RAW_INT)
      |=> raw_int == (($past(raw_int) & ~$past(req_i.wdata)) | $past(int_event_i)))
      else $error("write-one-to-clear disturbed other bits");

   chk_read_writeback: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      rd_at(rfa_pkg::OFS_RAW_INT) && int_event_i == 32'h0
      ##1 int_event_i == 32'h0 && !wr_at(rfa_pkg::OFS_RAW_INT) && !wr_at(rfa_pkg::OFS_INT_CLR)
      ##1 wr_at(rfa_pkg::OFS_RAW_INT) && req_i.wdata == $past(rsp.rdata) && int_event_i == 32'h0
      |=> raw_int == 32'h0)
      else $error("writeback of read status left reported bits set");

   chk_setbits_set: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      wr_at(rfa_pkg::OFS_SETBITS)
      |=> (setbits & $past(req_i.wdata)) == $past(req_i.wdata)
          && (setbits | $past(req_i.wdata)) == (($past(setbits) & ~$past(setbits_clear_i))
                                                | $past(req_i.wdata)))
      else $error("write-one-to-set misbehaved");

   chk_clear_reg: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      wr_at(rfa_pkg::OFS_INT_CLR)
      |=> (raw_int & $past(req_i.wdata) & ~$past(int_event_i)) == 32'h0
          && (raw_int & ~$past(req_i.wdata)) == (($past(raw_int) | $past(int_event_i))
                                                 & ~$past(req_i.wdata)))
      else $error("clear register did not clear status bits");

   chk_wo_read_zero: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      rd_at(rfa_pkg::OFS_WDATA) || rd_at(rfa_pkg::OFS_INT_CLR) |=> rsp.rdata == 32'h0)
      else $error("write-only register read nonzero");

   chk_wo_strobe: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      wr_at(rfa_pkg::OFS_WDATA) |=> wdata_strobe_o && wdata_o == $past(req_i.wdata)
      ##1 (wdata_strobe_o == $past(wr_at(rfa_pkg::OFS_WDATA))))
      else $error("write-only data not taken");

   chk_reserved_zero: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      rd_at(rfa_pkg::OFS_CTRL) |=> (rsp.rdata & ~CTRL_BITS) == 32'h0)
      else $error("reserved control bits read nonzero");

   chk_base_decode: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      req_i.sel && req_i.addr[31:rfa_pkg::OFS_BITS] != BASE_ADDR[31:rfa_pkg::OFS_BITS]
      |=> rsp.rdata == 32'h0 && $stable(ctrl) && $stable(wdata_o))
      else $error("access outside base window had an effect");

   chk_status_ro: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      rd_at(rfa_pkg::OFS_STATUS) |=> rsp.rdata == ($past(status_i) & rfa_pkg::STATUS_MASK))
      else $error("status read wrong");

endmodule

// *** rfa_sw_model.sv ***
/*
   Software-side bus master for the field access bank: one word access at a time.
   Assumes the bank takes a request on the rising edge and answers one cycle later.
*/
`timescale 1ns/1ns

module rfa_sw_model (
   // Clock
   input  wire logic              core_clk_i,
   // Bus toward the bank
   output rfa_pkg::rfa_req_t      req_o,
   input  wire rfa_pkg::rfa_rsp_t rsp_i
);

   initial req_o = '0;

   // -----------------------------------------------------------------
   // Access
   // -----------------------------------------------------------------
   // Between accesses the address and data are inverted so stale values never match.
   task automatic access(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
                         output logic [31:0] rd, output logic vld);
      @(negedge core_clk_i);
      req_o = {1'b1, wr, addr, wd};
      @(negedge core_clk_i);
      vld   = rsp_i.valid;
      rd    = rsp_i.rdata;
      req_o = {1'b0, ~wr, ~addr, ~wd};
   endtask

endmodule

// *** register_field_access_types_tb.sv ***
/*
   Self-checking bench for the field access bank, with scenario tasks that each cover one or more access types.
   Assumes the bank answers every taken request exactly one cycle later.
*/
`timescale 1ns/1ns

module register_field_access_types_tb;

   logic              core_clk_i;
   logic              reset_n_i;
   rfa_pkg::rfa_req_t req;
   rfa_pkg::rfa_rsp_t rsp;
   logic [31:0]       status;
   logic [31:0]       cap_ev;
   logic [31:0]       acc_ev;
   logic [31:0]       int_ev;
   logic [31:0]       sb_clr;
   logic [31:0]       ctrl;
   logic [31:0]       raw_int;
   logic [31:0]       setbits;
   logic [31:0]       wdata;
   logic              wstb;
   logic [31:0]       d;
   logic              v;
   int                failures = 0;
   int                samples_checked = 0;
   int                cycles = 0;

   rfa_sw_model sw (.core_clk_i(core_clk_i), .req_o(req), .rsp_i(rsp));

   rfa_bank dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .req_i(req), .rsp_o(rsp),
      .status_i(status), .capture_event_i(cap_ev), .accum_event_i(acc_ev),
      .int_event_i(int_ev), .setbits_clear_i(sb_clr), .ctrl_o(ctrl), .raw_int_o(raw_int),
      .setbits_o(setbits), .wdata_o(wdata), .wdata_strobe_o(wstb));

   // -----------------------------------------------------------------
   // Clock, reset and timeout
   // -----------------------------------------------------------------
   initial
   begin
      core_clk_i = 1'b0;
      forever #2 core_clk_i = ~core_clk_i;
   end

   always @(posedge core_clk_i)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         failures++;
         end_sim();
      end
   end

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string what);
      samples_checked++;
      if (got !== exp)
      begin
         failures++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [11:0] ofs, input logic [31:0] wd);
      sw.access(1'b1, rfa_pkg::BASE_DEFAULT + {20'h0, ofs}, wd, d, v);
      chk({v, d}, {1'b1, 32'h0000_0000}, "write answer");
   endtask

   task automatic rd(input logic [11:0] ofs, input logic [31:0] exp);
      sw.access(1'b0, rfa_pkg::BASE_DEFAULT + {20'h0, ofs}, 32'h0000_0000, d, v);
      chk({v, d}, {1'b1, exp}, "read data");
   endtask

   task automatic pulse(input int which, input logic [31:0] val);
      @(negedge core_clk_i);
      case (which)
         0: cap_ev = val;
         1: acc_ev = val;
         2: int_ev = val;
         default: sb_clr = val;
      endcase
      @(negedge core_clk_i);
      {cap_ev, acc_ev, int_ev, sb_clr} = '0;
   endtask

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic t_reset();
      for (int i = 0; i < 8; i++)
         rd(12'(i * 4), 32'h0000_0000);
      chk({1'b0, ctrl | raw_int | setbits | wdata}, 33'h0_0000_0000, "reset outputs");
      $display("test reset done");
   endtask

   task automatic t_ctrl_status();
      wr(rfa_pkg::OFS_CTRL, 32'hFFFF_FFFF);
      rd(rfa_pkg::OFS_CTRL, 32'h0000_FFFF);
      chk({1'b0, ctrl}, 33'h0_0000_FFFF, "control output");
      wr(rfa_pkg::OFS_CTRL, d & 32'h0000_5A5A);
      rd(rfa_pkg::OFS_CTRL, 32'h0000_5A5A);
      status = 32'hA5A5_A5A5;
      wr(rfa_pkg::OFS_STATUS, 32'h0000_0000);
      rd(rfa_pkg::OFS_STATUS, 32'h0000_00A5);
      sw.access(1'b1, rfa_pkg::BASE_DEFAULT + 32'h0000_1000, 32'h0000_0001, d, v);
      chk({v, d}, {1'b1, 32'h0000_0000}, "outside window answer");
      rd(rfa_pkg::OFS_CTRL, 32'h0000_5A5A);
      rd(12'h020, 32'h0000_0000);
      $display("test control and status done");
   endtask

   task automatic t_clear_types();
      pulse(0, 32'h0000_003C);
      rd(rfa_pkg::OFS_CAPTURE, 32'h0000_003C);
      rd(rfa_pkg::OFS_CAPTURE, 32'h0000_0000);
      pulse(1, 32'h0000_00F0);
      rd(rfa_pkg::OFS_ACCUM, 32'h0000_00F0);
      wr(rfa_pkg::OFS_ACCUM, 32'h0000_0000);
      rd(rfa_pkg::OFS_ACCUM, 32'h0000_0000);
      $display("test clear types done");
   endtask

   task automatic t_interrupts();
      pulse(2, 32'h0000_000F);
      wr(rfa_pkg::OFS_RAW_INT, 32'h0000_0005);
      rd(rfa_pkg::OFS_RAW_INT, 32'h0000_000A);
      pulse(2, 32'h0000_0030);
      wr(rfa_pkg::OFS_RAW_INT, 32'h0000_000A);
      rd(rfa_pkg::OFS_RAW_INT, 32'h0000_0030);
      wr(rfa_pkg::OFS_INT_CLR, 32'h0000_0010);
      chk({1'b0, raw_int}, 33'h0_0000_0020, "interrupt status");
      rd(rfa_pkg::OFS_INT_CLR, 32'h0000_0000);
      rd(rfa_pkg::OFS_RAW_INT, 32'h0000_0020);
      wr(rfa_pkg::OFS_RAW_INT, d);
      rd(rfa_pkg::OFS_RAW_INT, 32'h0000_0000);
      $display("test interrupts done");
   endtask

   task automatic t_set_and_data();
      wr(rfa_pkg::OFS_SETBITS, 32'h0000_0011);
      wr(rfa_pkg::OFS_SETBITS, 32'h0000_0000);
      rd(rfa_pkg::OFS_SETBITS, 32'h0000_0011);
      pulse(3, 32'h0000_0001);
      chk({1'b0, setbits}, 33'h0_0000_0010, "set bits output");
      wr(rfa_pkg::OFS_WDATA, 32'h1234_5678);
      chk({wstb, wdata}, {1'b1, 32'h1234_5678}, "write-only data");
      @(negedge core_clk_i);
      chk({wstb, 32'h0000_0000}, 33'h0_0000_0000, "data strobe width");
      rd(rfa_pkg::OFS_WDATA, 32'h0000_0000);
      $display("test set and data done");
   endtask

   // A second reset in mid-run must return every written field to zero.
   task automatic t_mid_reset();
      status    = 32'h0000_0000;
      reset_n_i = 1'b0;
      repeat (3) @(negedge core_clk_i);
      reset_n_i = 1'b1;
      t_reset();
      $display("test mid-run reset done");
   endtask

   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial
   begin
      reset_n_i = 1'b0;
      {status, cap_ev, acc_ev, int_ev, sb_clr} = '0;
      repeat (12) @(negedge core_clk_i);
      reset_n_i = 1'b1;
      t_reset();
      t_ctrl_status();
      t_clear_types();
      t_interrupts();
      t_set_and_data();
      t_mid_reset();
      end_sim();
   end

endmodule
